//--- ads_amp_seq.sv
// ads_amp_seq.sv: serial target that takes two instruction bytes and returns four diagnostic bytes
// assumes synchronous bus pins, analog status on diag_in and per-channel offset comparators
`timescale 1ns/1ns
`include "ads_params.svh"
module ads_amp_seq
    import ads_pkg::*;
#(
    parameter int WAIT_CYC = `ADS_WAIT_CYC
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input ads_diag_t diag_in,
    input wire logic [3:0] chan_offset,
    output ads_byte_t instruction_byte_one,
    output ads_byte_t instruction_byte_two,
    output logic amp_on,
    output logic quiet_on,
    output logic diag_launch,
    output logic offset_active,
    output logic wait_busy
);
    ads_line_t ev;
    ads_state_t state_r, state_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    ads_byte_t sh_r, sh_nxt, tx_r, tx_nxt;
    ads_byte_t pend1_r, pend1_nxt, pend2_r, pend2_nxt;
    logic rw_r, rw_nxt;
    logic [1:0] wr_cnt_r, wr_cnt_nxt;
    logic [1:0] rd_idx_r, rd_idx_nxt;
    logic sda_oe_r, sda_oe_nxt, sda_out_r;
    ads_diag_t snap_r, snap_nxt;
    ads_byte_t ib1_r, ib2_r;
    logic amp_on_r, quiet_on_r, diag_launch_r, offset_active_r, wait_busy_r;
    logic [3:0] offset_seen_r;
    logic [15:0] wait_cnt_r;

    ads_line_mon u_line (
        .clk(clk),
        .nrst(nrst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ev(ev)
    );

    // byte boundary and address decode
    wire logic byte_done = ev.scl_fall & (bit_cnt_r == `ADS_BYTE_BITS);
    wire logic addr_hit = sh_r[7:1] == `ADS_DEV_ADDR;
    wire logic rd_hit = (state_r == ADS_ADDR) & byte_done & addr_hit & sh_r[`ADS_RW_BIT];
    wire logic commit = ev.stop & (wr_cnt_r == `ADS_WR_BYTES);
    wire logic ofs_cmd = ((pend1_r & `ADS_OFS_IB1_MASK) == `ADS_OFS_IB1_MASK) & pend2_r[`ADS_IB2_STBY_BIT];
    wire logic qon_cmd = ((pend1_r & `ADS_QON_IB1_MASK) == `ADS_QON_IB1_VAL)
        & ((pend2_r & `ADS_QON_IB2_MASK) == `ADS_QON_IB2_VAL);
    wire ads_byte_t rd_byte = snap_r.db[rd_idx_r];

    // snapshot of the diagnostic bytes, built per channel
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : g_snap
            wire ads_byte_t raw = diag_in.db[ch];
            wire logic ofs_bit = offset_active_r ? (offset_seen_r[ch] | chan_offset[ch]) :
                raw[`ADS_DB_PERM_BIT] ? chan_offset[ch] : raw[`ADS_DB_OFS_BIT];
            if (ch == 2) begin : g_mirror
                assign snap_nxt.db[ch] = {ib2_r[`ADS_IB2_STBY_BIT], ib1_r[`ADS_IB1_DIAG_BIT], raw[5:3], ofs_bit,
                    raw[1:0]};
            end else begin : g_plain
                assign snap_nxt.db[ch] = {raw[7:3], ofs_bit, raw[1:0]};
            end
        end
    endgenerate

    // serial target sequencing
    always_comb begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        pend1_nxt = pend1_r;
        pend2_nxt = pend2_r;
        rw_nxt = rw_r;
        wr_cnt_nxt = wr_cnt_r;
        rd_idx_nxt = rd_idx_r;
        sda_oe_nxt = sda_oe_r;
        if (ev.start) begin
            state_nxt = ADS_ADDR;
            bit_cnt_nxt = 4'h0;
            wr_cnt_nxt = 2'h0;
            sda_oe_nxt = 1'b0;
        end else if (ev.stop) begin
            state_nxt = ADS_IDLE;
            wr_cnt_nxt = 2'h0;
            sda_oe_nxt = 1'b0;
        end else begin
            case (state_r)
                ADS_ADDR, ADS_WR: begin
                    if (ev.scl_rise) begin
                        sh_nxt = {sh_r[6:0], ev.sda};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end
                    if (byte_done && state_r == ADS_ADDR) begin
                        state_nxt = addr_hit ? ADS_ACK : ADS_SKIP;
                        sda_oe_nxt = addr_hit;
                        rw_nxt = sh_r[`ADS_RW_BIT];
                        rd_idx_nxt = 2'h0;
                    end else if (byte_done && wr_cnt_r != `ADS_WR_BYTES) begin
                        state_nxt = ADS_ACK;
                        sda_oe_nxt = 1'b1;
                        wr_cnt_nxt = wr_cnt_r + 2'h1;
                        if (wr_cnt_r == 2'h0) begin
                            pend1_nxt = sh_r;
                        end else begin
                            pend2_nxt = sh_r;
                        end
                    end else if (byte_done) begin
                        state_nxt = ADS_SKIP; // surplus byte is not acked
                    end
                end
                ADS_ACK: begin
                    if (ev.scl_fall) begin
                        bit_cnt_nxt = 4'h0;
                        if (rw_r) begin
                            state_nxt = ADS_RD;
                            tx_nxt = rd_byte;
                            sda_oe_nxt = ~rd_byte[7];
                        end else begin
                            state_nxt = ADS_WR;
                            sda_oe_nxt = 1'b0;
                        end
                    end
                end
                ADS_RD: begin
                    if (ev.scl_fall) begin
                        if (bit_cnt_r == 4'h7) begin
                            state_nxt = ADS_MACK;
                            sda_oe_nxt = 1'b0;
                        end else begin
                            tx_nxt = {tx_r[6:0], 1'b0};
                            sda_oe_nxt = ~tx_r[6];
                            bit_cnt_nxt = bit_cnt_r + 4'h1;
                        end
                    end
                end
                ADS_MACK: begin
                    // host ack moves to the next byte, nack ends
                    if (ev.scl_rise) begin
                        // the fourth byte ends the read, so the host's stop is never blocked
                        state_nxt = (ev.sda || rd_idx_r == 2'h3) ? ADS_SKIP : ADS_MACK;
                        rd_idx_nxt = rd_idx_r + 2'h1;
                    end else if (ev.scl_fall) begin
                        state_nxt = ADS_RD;
                        bit_cnt_nxt = 4'h0;
                        tx_nxt = rd_byte;
                        sda_oe_nxt = ~rd_byte[7];
                    end
                end
                ADS_IDLE, ADS_SKIP: begin
                    sda_oe_nxt = 1'b0;
                end
                default: begin
                    state_nxt = ADS_IDLE;
                    sda_oe_nxt = 1'b0;
                end
            endcase
        end
    end

    // serial target registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ADS_IDLE;
            bit_cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            pend1_r <= `ADS_IB_RST;
            pend2_r <= `ADS_IB_RST;
            rw_r <= 1'b0;
            wr_cnt_r <= 2'h0;
            rd_idx_r <= 2'h0;
            sda_oe_r <= 1'b0;
            sda_out_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            sh_r <= sh_nxt;
            tx_r <= tx_nxt;
            pend1_r <= pend1_nxt;
            pend2_r <= pend2_nxt;
            rw_r <= rw_nxt;
            wr_cnt_r <= wr_cnt_nxt;
            rd_idx_r <= rd_idx_nxt;
            sda_oe_r <= sda_oe_nxt;
            sda_out_r <= 1'b0; // open drain, only ever pulls low
        end
    end

    // snapshot taken as the read address is acked
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            snap_r <= '0;
        end else if (rd_hit) begin
            snap_r <= snap_nxt;
        end
    end

    // both instruction bytes applied together at stop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ib1_r <= `ADS_IB_RST;
            ib2_r <= `ADS_IB_RST;
            amp_on_r <= 1'b0;
            quiet_on_r <= 1'b0;
            diag_launch_r <= 1'b0;
        end else begin
            if (commit) begin
                ib1_r <= pend1_r;
                ib2_r <= pend2_r;
                // off only when both bits clear
                amp_on_r <= pend1_r[`ADS_IB1_DIAG_BIT] | pend2_r[`ADS_IB2_STBY_BIT];
                quiet_on_r <= qon_cmd;
            end
            diag_launch_r <= commit & pend1_r[`ADS_IB1_DIAG_BIT];
        end
    end

    // offset procedure: sticky per-channel flags, start by command, stop by read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            offset_active_r <= 1'b0;
            offset_seen_r <= 4'h0;
        end else begin
            if (rd_hit) begin
                offset_active_r <= 1'b0;
            end else if (commit) begin
                offset_active_r <= ofs_cmd;
            end
            // comparator flag wins over the restart clear
            if (commit && ofs_cmd) begin
                offset_seen_r <= chan_offset;
            end else if (offset_active_r) begin
                offset_seen_r <= offset_seen_r | chan_offset;
            end
        end
    end

    // settle window after launch or offset enable
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_cnt_r <= 16'h0000;
            wait_busy_r <= 1'b0;
        end else if (commit && (pend1_r[`ADS_IB1_DIAG_BIT] || ofs_cmd)) begin
            wait_cnt_r <= 16'(WAIT_CYC - 1);
            wait_busy_r <= 1'b1;
        end else if (wait_cnt_r != 16'h0000) begin
            wait_cnt_r <= wait_cnt_r - 16'h0001;
        end else begin
            wait_busy_r <= 1'b0;
        end
    end

    assign sda_out = sda_out_r;
    assign sda_oe = sda_oe_r;
    assign instruction_byte_one = ib1_r;
    assign instruction_byte_two = ib2_r;
    assign amp_on = amp_on_r;
    assign quiet_on = quiet_on_r;
    assign diag_launch = diag_launch_r;
    assign offset_active = offset_active_r;
    assign wait_busy = wait_busy_r;

    // checks beside the logic
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    commit_both_a: assert property (commit |=> ib1_r == $past(pend1_r) && ib2_r == $past(pend2_r))
        else $error("instruction bytes not applied together at stop");
    launch_pulse_a: assert property (commit && pend1_r[6] |=> diag_launch_r ##1 !diag_launch_r)
        else $error("diagnostic launch not a single pulse after stop");
    amp_off_a: assert property (commit && !pend1_r[6] && !pend2_r[4] |=> !amp_on_r)
        else $error("amplifier not off after off command");
    quiet_on_a: assert property (commit && pend1_r[6:0] == 7'h00 && pend2_r[4] && pend2_r[1:0] == 2'h3
        |=> amp_on_r && quiet_on_r)
        else $error("quiet turn-on not applied");
    offset_start_a: assert property (commit && pend1_r[5] && pend1_r[2] && pend1_r[1] && pend2_r[4]
        |=> offset_active_r)
        else $error("offset detection not started");
    offset_stop_a: assert property (offset_active_r && rd_hit |=> !offset_active_r && snap_r.db[0][2]
        == $past(offset_seen_r[0] | chan_offset[0]))
        else $error("read did not stop offset detection or lost result");
    stby_mirror_a: assert property (rd_hit |=> snap_r.db[2][7] == ib2_r[4] && snap_r.db[2][6] == ib1_r[6])
        else $error("third diagnostic byte mirror bits wrong");
    addr_ack_a: assert property (state_r == ADS_ADDR && byte_done && addr_hit
        |=> sda_oe_r && state_r == ADS_ACK)
        else $error("own address not acked");
    ack_hold_a: assert property (state_r == ADS_ACK |-> sda_oe_r)
        else $error("acknowledge released early");
    first_byte_a: assert property (rd_hit |=> rd_idx_r == 2'h0)
        else $error("read does not start at diagnostic byte one");
    rd_end_a: assert property (state_r == ADS_MACK && ev.scl_rise && rd_idx_r == 2'h3
        |=> state_r == ADS_SKIP && !sda_oe_r)
        else $error("data line still driven after the fourth byte");
    wait_window_a: assert property (diag_launch_r |-> wait_busy_r)
        else $error("settle window not running after launch");
    perm_offset_a: assert property (rd_hit && !offset_active_r && diag_in.db[1][4]
        |=> snap_r.db[1][2] == $past(chan_offset[1]))
        else $error("permanent-mode offset bit wrong");

    write_cov_c: cover property (commit);
    read_cov_c: cover property (rd_hit ##[1:1000] state_r == ADS_MACK);
    offset_cov_c: cover property (offset_active_r ##1 rd_hit);
    launch_cov_c: cover property (diag_launch_r);
endmodule

//--- ads_params.svh
// ads_params.svh: offsets, bit positions, patterns and timing counts for the amplifier command sequencer
// assumes a 20 MHz core clock; included by bare name, definitions only
`ifndef ADS_PARAMS_SVH
`define ADS_PARAMS_SVH

// target address, arbitrary neutral value
`define ADS_DEV_ADDR 7'h2A
// direction bit of the address byte, 1 = read
`define ADS_RW_BIT 0
// instruction byte one: diagnostic launch bit
`define ADS_IB1_DIAG_BIT 6
// instruction byte two: standby control bit, 1 = amplifier on
`define ADS_IB2_STBY_BIT 4
// diagnostic bytes: offset result bit and permanent-mode flag bit
`define ADS_DB_OFS_BIT 2
`define ADS_DB_PERM_BIT 4
// third diagnostic byte: mirrored standby and launch bits
`define ADS_DB3_STBY_BIT 7
`define ADS_DB3_DIAG_BIT 6
// offset detection enable pattern in instruction byte one (bits 5, 2, 1)
`define ADS_OFS_IB1_MASK 8'h26
// quiet turn-on pattern: 26 dB, mute, diag defeat, 2 % clip threshold
`define ADS_QON_IB1_MASK 8'h7F
`define ADS_QON_IB1_VAL 8'h00
`define ADS_QON_IB2_MASK 8'h13
`define ADS_QON_IB2_VAL 8'h13
// reset value of both instruction bytes
`define ADS_IB_RST 8'h00
// bits per byte and bytes per control write
`define ADS_BYTE_BITS 4'h8
`define ADS_WR_BYTES 2'h2
// least wait from launch to read, in ms, and the core clock rate
`define ADS_WAIT_MS 1
`define ADS_CLK_HZ 20000000
`define ADS_WAIT_CYC ((`ADS_WAIT_MS * `ADS_CLK_HZ) / 1000)

`endif

//--- ads_pkg.sv
// ads_pkg.sv: types shared by the amplifier command sequencer files
// assumes ads_params.svh holds all numeric constants
package ads_pkg;
    typedef logic [7:0] ads_byte_t;

    // the four diagnostic bytes, index 0 = diag_byte_one
    typedef struct packed {
        ads_byte_t [3:0] db;
    } ads_diag_t;

    // bus line events from the line monitor
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } ads_line_t;

    // serial target states, one-hot
    typedef enum logic [6:0] {
        ADS_IDLE = 7'b000_0001,
        ADS_ADDR = 7'b000_0010,
        ADS_ACK = 7'b000_0100,
        ADS_WR = 7'b000_1000,
        ADS_RD = 7'b001_0000,
        ADS_MACK = 7'b010_0000,
        ADS_SKIP = 7'b100_0000
    } ads_state_t;
endpackage

//--- ads_line_mon.sv
// ads_line_mon.sv: edge and start/stop detection on the serial clock and data lines
// assumes scl and sda are already synchronous to clk
`timescale 1ns/1ns
module ads_line_mon
    import ads_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output ads_line_t ev
);
    logic scl_r;
    logic sda_r;

    // previous line levels, idle bus is high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
        end else begin
            scl_r <= scl_in;
            sda_r <= sda_in;
        end
    end

    // start: sda falls with scl high; stop: sda rises with scl high
    assign ev.start = scl_r & scl_in & sda_r & ~sda_in;
    assign ev.stop = scl_r & scl_in & ~sda_r & sda_in;
    assign ev.scl_rise = ~scl_r & scl_in;
    assign ev.scl_fall = scl_r & ~scl_in;
    assign ev.sda = sda_in;
endmodule

//--- ads_bus_host.sv
// ads_bus_host.sv: behavioural serial bus controller facing the command sequencer
// assumes the device pulls sda low through dev_oe; the data line has a pull-up
`timescale 1ns/1ns
module ads_bus_host
    import ads_pkg::*;
#(
    parameter int HALF = 6
)
(
    input wire logic clk,
    input wire logic dev_oe,
    input wire logic dev_out,
    output logic scl,
    output logic sda
);
    logic host_low_r = 1'b0;
    logic scl_r = 1'b1;

    // wired-and data line, released level is high; clock idles high
    assign sda = ~(host_low_r | (dev_oe & ~dev_out));
    assign scl = scl_r;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one clock pulse; data set one cycle after the fall, sampled mid-high
    task automatic pulse(input logic lo, output logic b);
        cyc(1);
        host_low_r <= lo;
        cyc(HALF);
        scl_r <= 1'b1;
        cyc(HALF / 2);
        b = sda;
        cyc(HALF - HALF / 2);
        scl_r <= 1'b0;
    endtask

    task automatic bus_start();
        host_low_r <= 1'b1;
        cyc(HALF);
        scl_r <= 1'b0;
    endtask

    task automatic bus_stop();
        cyc(1);
        host_low_r <= 1'b1;
        cyc(HALF);
        scl_r <= 1'b1;
        cyc(HALF);
        host_low_r <= 1'b0;
        cyc(HALF);
    endtask

    task automatic wr_byte(input ads_byte_t d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) pulse(~d[i], b);
        pulse(1'b0, b);
        ack = ~b;
    endtask

    task automatic rd_byte(input logic ack, output ads_byte_t d);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b0, b);
            d[i] = b;
        end
        pulse(ack, b);
    endtask
endmodule

//--- ads_amp_seq_tb_top.sv
// ads_amp_seq_tb_top.sv: self-checking bench for the amplifier command sequencer
// assumes ads_bus_host as controller and a shortened diagnostic wait
`timescale 1ns/1ns
`include "ads_params.svh"
module ads_amp_seq_tb_top
    import ads_pkg::*;
;
    localparam int WAITC = 20;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic scl, sda, sda_out, sda_oe, amp_on, quiet_on, diag_launch, offset_active, wait_busy;
    ads_byte_t instruction_byte_one, instruction_byte_two, ib1_e, ib2_e;
    ads_diag_t diag_in = '0;
    logic [3:0] chan_offset = 4'h0;
    ads_byte_t rd[4];
    int num_errors = 0;
    int checked = 0;
    int launches = 0;
    int launch_e = 0;

    // 20 MHz clock
    always #25 clk = ~clk;

    // count launch pulses
    always @(posedge clk) if (diag_launch === 1'b1) launches <= launches + 1;

    ads_amp_seq #(.WAIT_CYC(WAITC)) dut (
        .clk(clk),
        .nrst(nrst),
        .scl_in(scl),
        .sda_in(sda),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .diag_in(diag_in),
        .chan_offset(chan_offset),
        .instruction_byte_one(instruction_byte_one),
        .instruction_byte_two(instruction_byte_two),
        .amp_on(amp_on),
        .quiet_on(quiet_on),
        .diag_launch(diag_launch),
        .offset_active(offset_active),
        .wait_busy(wait_busy)
    );

    ads_bus_host #(.HALF(6)) host (
        .clk(clk),
        .dev_oe(sda_oe),
        .dev_out(sda_out),
        .scl(scl),
        .sda(sda)
    );

    task automatic cmp_byte(input ads_byte_t got, input ads_byte_t exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_byte({7'h00, got}, {7'h00, exp});
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // new raw status and comparator levels
    task automatic new_inputs();
        @(posedge clk);
        diag_in <= ads_diag_t'($urandom);
        chan_offset <= 4'($urandom);
    endtask

    // full control write and its effects at the ports
    task automatic wr_cmd(input ads_byte_t b1, input ads_byte_t b2);
        logic a;
        host.bus_start();
        host.wr_byte({`ADS_DEV_ADDR, 1'b0}, a);
        cmp_bit(a, 1'b1); // address ack
        host.wr_byte(b1, a);
        cmp_bit(a, 1'b1); // first byte ack
        host.wr_byte(b2, a);
        cmp_bit(a, 1'b1); // second byte ack
        host.bus_stop();
        ib1_e = b1;
        ib2_e = b2;
        if (b1[6]) launch_e++;
        cmp_byte(instruction_byte_one, b1); // both bytes applied
        cmp_byte(instruction_byte_two, b2); // both bytes applied
        cmp_bit(amp_on, b1[6] | b2[4]); // on or off
        cmp_bit(quiet_on, b1[6:0] == 7'h00 && (b2 & 8'h13) == 8'h13); // quiet turn-on
        cmp_byte(launches[7:0], launch_e[7:0]); // launch pulses
    endtask

    // read of the four status bytes, every one acked by the host, then stop
    task automatic rd_diag();
        logic a;
        host.bus_start();
        host.wr_byte({`ADS_DEV_ADDR, 1'b1}, a);
        cmp_bit(a, 1'b1); // read address ack
        for (int i = 0; i < 4; i++) host.rd_byte(1'b1, rd[i]); // host acks all four
        host.bus_stop();
    endtask

    // expected status byte outside offset detection
    function automatic ads_byte_t exp_db(input int i);
        ads_byte_t r;
        r = diag_in.db[i];
        if (r[4]) r[2] = chan_offset[i];
        if (i == 2) r[7:6] = {ib2_e[4], ib1_e[6]};
        return r;
    endfunction

    initial begin
        ads_byte_t b1, b2;
        logic [3:0] ofs;
        logic a;
        void'($urandom(56131));
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        cmp_byte(instruction_byte_one, 8'h00); // reset value
        cmp_bit(amp_on, 1'b0); // off at reset
        // random writes: on/off table, quiet pattern, launches, then read back
        for (int k = 0; k < 8; k++) begin
            new_inputs();
            b1 = 8'($urandom) & 8'hDF;
            b2 = 8'($urandom);
            if (k < 4) begin
                b1[6] = k[0];
                b2[4] = k[1];
            end
            if (k == 4) begin
                b1[6:0] = 7'h00;
                b2 = b2 | 8'h13;
            end
            wr_cmd(b1, b2);
            if (b1[6]) begin
                cmp_bit(wait_busy, 1'b1); // wait started
                repeat (WAITC + 4) @(posedge clk);
                cmp_bit(wait_busy, 1'b0); // wait over
            end
            rd_diag();
            for (int i = 0; i < 4; i++) cmp_byte(rd[i], exp_db(i)); // byte order
            $display("test write_read %0d done", k);
        end
        // offset detection: enable, a second channel event, read stops it
        new_inputs();
        b1 = 8'($urandom) | 8'h26;
        b2 = 8'($urandom) | 8'h10;
        wr_cmd(b1, b2);
        cmp_bit(offset_active, 1'b1); // procedure running
        cmp_bit(wait_busy, 1'b1); // wait started
        ofs = chan_offset;
        @(posedge clk);
        chan_offset <= 4'($urandom);
        repeat (WAITC + 4) @(posedge clk);
        ofs = ofs | chan_offset;
        rd_diag();
        cmp_bit(offset_active, 1'b0); // read stops it
        for (int i = 0; i < 4; i++) cmp_bit(rd[i][2], ofs[i]); // offset flags
        $display("test offset done");
        // other address, short write and a third byte are refused
        host.bus_start();
        host.wr_byte({`ADS_DEV_ADDR ^ 7'h01, 1'b0}, a);
        cmp_bit(a, 1'b0); // foreign address
        host.bus_stop();
        host.bus_start();
        host.wr_byte({`ADS_DEV_ADDR, 1'b0}, a);
        host.wr_byte(~b1, a);
        host.bus_stop();
        cmp_byte(instruction_byte_one, b1); // short write ignored
        host.bus_start();
        host.wr_byte({`ADS_DEV_ADDR, 1'b0}, a);
        host.wr_byte(b1, a);
        host.wr_byte(b2, a);
        host.wr_byte(b2, a);
        cmp_bit(a, 1'b0); // third byte refused
        host.bus_stop();
        $display("test refusals done");
        end_of_test();
    end
endmodule
